/* File: rtl/ptg_core.sv */
// wake channel, reference tracking, reseed command and gesture logic
`timescale 1ns/1ps
`include "ptg_cfg.svh"
module ptg_core #(
	parameter int unsigned STEP_CYC    = `PTG_STEP_CYC,
	parameter logic [15:0] TUNE_TARGET = 16'h0320
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [7:0]  wr_addr,
	input  wire logic [15:0] wr_data,
	input  wire logic [7:0]  rd_addr,
	output logic      [15:0] rd_data_r,
	input  wire logic        redo_tune_cmd,
	input  wire logic        bus_stop,
	input  wire logic        sample_valid,
	input  wire logic [15:0] wake_counts,
	input  wire logic [15:0] ref_counts,
	input  wire logic [7:0]  ref_weight,
	input  wire logic        tp_touch,
	input  wire logic [7:0]  tp_x,
	input  wire logic [7:0]  tp_y,
	output logic             wake_prox_r,
	output logic             wake_touch_r,
	output logic      [15:0] wake_lta_r,
	output logic      [15:0] ref_lta_r,
	output logic      [7:0]  reseed_ch_r,
	output logic      [7:0]  retune_ch_r,
	output logic             swipe_x_r,
	output logic             swipe_y_r,
	output logic             tap_r
);
	logic        rst_s1_r, rst_sn_r;
	logic [15:0] cfg_r, cfg_nxt, tmo_r, tmo_nxt, thr_r, thr_nxt;
	logic [15:0] hys_r, hys_nxt, rd_nxt;
	logic [7:0]  cmd_r, cmd_nxt;
	logic        redo_r, redo_nxt;
	logic [7:0]  rsd_nxt, rtn_nxt;
	logic [15:0] wlta_nxt, rlta_nxt, delta, rdelta, rsd_val;
	logic        prox_nxt, touch_nxt, wake_rsd, ref_rsd, cond, band_bad;
	logic [17:0] touch_thr, rel_thr;
	logic [23:0] wt_prod;
	logic [25:0] rel_prod;
	logic [1:0]  rank;

	// released reset copy; async assert, two-flop release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_sn_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_sn_r <= rst_s1_r;
		end
	end

	// absolute difference, used by every coordinate check
	function automatic logic [7:0] adiff(input logic [7:0] a,
		input logic [7:0] b);
		adiff = (a > b) ? a - b : b - a;
	endfunction

	// release fraction numerator out of 256
	function automatic logic [7:0] hyst_frac(input logic [3:0] c);
		logic [127:0] tab;
		tab = 128'hc3a7_907b_6755_4537_2a1f_150e_0803_0100; // code 0 lowest
		hyst_frac = tab[{c, 3'b000} +: 8];
	endfunction

	// register writes, readback and the deferred reseed command
	always_comb begin
		cfg_nxt  = cfg_r;
		tmo_nxt  = tmo_r;
		thr_nxt  = thr_r;
		hys_nxt  = hys_r;
		cmd_nxt  = cmd_r;
		redo_nxt = redo_r | redo_tune_cmd;
		rsd_nxt  = 8'h00;
		rtn_nxt  = 8'h00;
		if (wr_en) begin
			case (wr_addr)
				`PTG_OFS_REF_GEST:   cfg_nxt = wr_data;
				`PTG_OFS_TIMEOUTS:   tmo_nxt = wr_data;
				`PTG_OFS_RESEED_CMD: cmd_nxt = wr_data[7:0] & 8'hf7;
				`PTG_OFS_WAKE_THR:   thr_nxt = wr_data;
				`PTG_OFS_WAKE_HYST:  hys_nxt = wr_data & 16'hff1f;
				default:             cmd_nxt = cmd_r;
			endcase
		end
		// act at stop; redo in the same window turns reseed to re-tune
		if (bus_stop) begin
			if (redo_nxt) rtn_nxt = cmd_nxt;
			else rsd_nxt = cmd_nxt;
			cmd_nxt  = `PTG_RST_CMD;
			redo_nxt = 1'b0;
		end
		// auto re-tune of the wake channel after an out-of-band reseed
		if (wake_rsd && band_bad) rtn_nxt[0] = 1'b1;
		case (rd_addr)
			`PTG_OFS_REF_GEST:   rd_nxt = cfg_r;
			`PTG_OFS_TIMEOUTS:   rd_nxt = tmo_r;
			`PTG_OFS_RESEED_CMD: rd_nxt = {8'h00, cmd_r};
			`PTG_OFS_WAKE_THR:   rd_nxt = thr_r;
			`PTG_OFS_WAKE_HYST:  rd_nxt = hys_r;
			default:             rd_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sn_r) begin
		if (!rst_sn_r) begin
			cfg_r       <= `PTG_RST_REG;
			tmo_r       <= `PTG_RST_REG;
			thr_r       <= `PTG_RST_REG;
			hys_r       <= `PTG_RST_REG;
			cmd_r       <= `PTG_RST_CMD;
			redo_r      <= 1'b0;
			reseed_ch_r <= 8'h00;
			retune_ch_r <= 8'h00;
			rd_data_r   <= 16'h0000;
		end else begin
			cfg_r       <= cfg_nxt;
			tmo_r       <= tmo_nxt;
			thr_r       <= thr_nxt;
			hys_r       <= hys_nxt;
			cmd_r       <= cmd_nxt;
			redo_r      <= redo_nxt;
			reseed_ch_r <= rsd_nxt;
			retune_ch_r <= rtn_nxt;
			rd_data_r   <= rd_nxt;
		end
	end

	// wake channel thresholds, state flags, averages and tracking
	always_comb begin
		// mutual sensing pulls counts down, so the delta flips
		if (hys_r[`PTG_F_PROJECTED])
			delta = (wake_lta_r > wake_counts) ? wake_lta_r - wake_counts : 16'h0000;
		else
			delta = (wake_counts > wake_lta_r) ? wake_counts - wake_lta_r : 16'h0000;
		rdelta = (ref_counts > ref_lta_r) ? ref_counts - ref_lta_r
			: ref_lta_r - ref_counts;
		touch_thr = {2'b00, 16'((24'(thr_r[15:8]) * 24'(wake_lta_r)) >> 8)};
		if (cfg_r[`PTG_F_EXTEND]) touch_thr = touch_thr << 2;
		rel_prod = 26'(touch_thr) * (26'h100 - 26'(hyst_frac(hys_r[3:0])));
		rel_thr = rel_prod[25:8];
		prox_nxt  = wake_prox_r;
		touch_nxt = wake_touch_r;
		if (sample_valid) begin
			prox_nxt  = delta > {8'h00, thr_r[7:0]};
			// enter above touch, hold until delta drops to release
			touch_nxt = wake_touch_r ? ({2'b00, delta} > rel_thr)
				: ({2'b00, delta} > touch_thr);
		end
		cond = wake_prox_r | wake_touch_r;
		rank = wake_touch_r ? 2'd2 : (wake_prox_r ? 2'd1 : 2'd0);
		// reference event reseeds sensing channel in states up to the level
		ref_rsd = sample_valid && (rdelta > {8'h00, thr_r[7:0]})
			&& (rank <= cfg_r[`PTG_F_RSD_LVL_LO +: 2]);
		wake_rsd = rsd_nxt[0] | ref_rsd;
		rsd_val = wake_counts;
		if (cfg_r[`PTG_F_ADV_OFS])
			rsd_val = hys_r[`PTG_F_PROJECTED] ? wake_counts - `PTG_RESEED_OFS
				: wake_counts + `PTG_RESEED_OFS;
		band_bad = (rsd_val > TUNE_TARGET + (TUNE_TARGET >> `PTG_BAND_SHIFT))
			|| (rsd_val < TUNE_TARGET - (TUNE_TARGET >> `PTG_BAND_SHIFT));
		wt_prod = 24'(rdelta) * 24'(ref_weight); // weight/128: 0..~200%
		wlta_nxt = wake_lta_r;
		rlta_nxt = ref_lta_r;
		if (wake_rsd) begin
			wlta_nxt = rsd_val;
		end else if (sample_valid) begin
			if (cfg_r[`PTG_F_TRACK_EN] && cond) begin
				wlta_nxt = wake_lta_r - 16'(wt_prod >> 7);
			end else if (!cond) begin
				// slow follow; proximity halts it
				wlta_nxt = wake_lta_r + 16'($signed({1'b0, wake_counts})
					- $signed({1'b0, wake_lta_r}) >>> 4);
			end
			// frozen only while tracking an active channel
			if (!(cfg_r[`PTG_F_TRACK_EN] && cond))
				rlta_nxt = ref_counts;
		end
	end

	always_ff @(posedge clk or negedge rst_sn_r) begin
		if (!rst_sn_r) begin
			wake_prox_r  <= 1'b0;
			wake_touch_r <= 1'b0;
			wake_lta_r   <= 16'h0000;
			ref_lta_r    <= 16'h0000;
		end else begin
			wake_prox_r  <= prox_nxt & ~wake_rsd;
			wake_touch_r <= touch_nxt & ~wake_rsd;
			wake_lta_r   <= wlta_nxt;
			ref_lta_r    <= rlta_nxt;
		end
	end

	// gesture timing, coordinate filter and qualification
	ptg_pkg::ptg_gest_t gst_r, gst_nxt;
	logic [20:0] tick_r, tick_nxt;
	logic [7:0]  el_r, el_nxt, xf_r, xf_nxt, yf_r, yf_nxt;
	logic [7:0]  xs_r, xs_nxt, ys_r, ys_nxt;
	logic        sx_nxt, sy_nxt, tap_nxt, sw_x, sw_y, sw_time, tap_ok;
	logic [1:0]  cf;

	always_comb begin
		cf       = cfg_r[`PTG_F_CFILT_LO +: 2];
		gst_nxt  = gst_r;
		xs_nxt   = xs_r;
		ys_nxt   = ys_r;
		sx_nxt   = 1'b0;
		sy_nxt   = 1'b0;
		tap_nxt  = 1'b0;
		tick_nxt = tick_r + 21'd1;
		el_nxt   = el_r;
		if (tick_r >= 21'(STEP_CYC - 1)) begin
			tick_nxt = 21'd0;
			if (el_r != 8'hff) el_nxt = el_r + 8'd1;
		end
		// first-order filter on the gesture path only
		xf_nxt = xf_r;
		yf_nxt = yf_r;
		if (sample_valid) begin
			xf_nxt = 8'($signed({1'b0, xf_r}) + (($signed({1'b0, tp_x})
				- $signed({1'b0, xf_r})) >>> cf));
			yf_nxt = 8'($signed({1'b0, yf_r}) + (($signed({1'b0, tp_y})
				- $signed({1'b0, yf_r})) >>> cf));
		end
		sw_x    = adiff(xf_nxt, xs_r) > cfg_r[15:8];
		sw_y    = adiff(yf_nxt, ys_r) > cfg_r[15:8];
		sw_time = el_r < tmo_r[15:8];
		// raw coordinates for tap, limit is half the swipe threshold
		tap_ok  = (adiff(tp_x, xs_r) <= {1'b0, cfg_r[15:9]})
			&& (adiff(tp_y, ys_r) <= {1'b0, cfg_r[15:9]})
			&& (el_r < tmo_r[7:0]);
		if (sample_valid) begin
			case (gst_r)
				ptg_pkg::PTG_G_IDLE: begin
					if (tp_touch) begin
						gst_nxt  = ptg_pkg::PTG_G_TOUCH;
						xs_nxt   = tp_x;
						ys_nxt   = tp_y;
						xf_nxt   = tp_x;
						yf_nxt   = tp_y;
						el_nxt   = 8'h00;
						tick_nxt = 21'd0;
					end
				end
				ptg_pkg::PTG_G_TOUCH: begin
					if (!tp_touch) begin
						gst_nxt = ptg_pkg::PTG_G_IDLE;
						// flick reports only at release
						if (!cfg_r[`PTG_F_SWIPE_MODE] && sw_time) begin
							sx_nxt = sw_x;
							sy_nxt = sw_y;
						end
						tap_nxt = tap_ok && !(sw_time && (sw_x || sw_y)
							&& !cfg_r[`PTG_F_SWIPE_MODE]);
					end else if (cfg_r[`PTG_F_SWIPE_MODE] && sw_time
						&& (sw_x || sw_y)) begin
						gst_nxt = ptg_pkg::PTG_G_DONE;
						sx_nxt  = sw_x;
						sy_nxt  = sw_y;
					end
				end
				ptg_pkg::PTG_G_DONE: begin
					if (!tp_touch) gst_nxt = ptg_pkg::PTG_G_IDLE;
				end
				default: gst_nxt = ptg_pkg::PTG_G_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sn_r) begin
		if (!rst_sn_r) begin
			gst_r     <= ptg_pkg::PTG_G_IDLE;
			tick_r    <= 21'd0;
			el_r      <= 8'h00;
			xf_r      <= 8'h00;
			yf_r      <= 8'h00;
			xs_r      <= 8'h00;
			ys_r      <= 8'h00;
			swipe_x_r <= 1'b0;
			swipe_y_r <= 1'b0;
			tap_r     <= 1'b0;
		end else begin
			gst_r     <= gst_nxt;
			tick_r    <= tick_nxt;
			el_r      <= el_nxt;
			xf_r      <= xf_nxt;
			yf_r      <= yf_nxt;
			xs_r      <= xs_nxt;
			ys_r      <= ys_nxt;
			swipe_x_r <= sx_nxt;
			swipe_y_r <= sy_nxt;
			tap_r     <= tap_nxt;
		end
	end

	// checks on the block's own registers, thresholds and outputs
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sn_r);
	sequence s_stop_redo;
		bus_stop && (redo_r || redo_tune_cmd) && !wr_en;
	endsequence
	AST_CMD_CLEAR: assert property (bus_stop |=> cmd_r == 8'h00)
		else $error("command byte not cleared at stop");
	AST_RETUNE: assert property (s_stop_redo |=>
		retune_ch_r[7:1] == $past(cmd_r[7:1]) && reseed_ch_r == 8'h00)
		else $error("re-tune bits do not follow command");
	AST_REF_FREEZE: assert property (sample_valid && cfg_r[3]
		&& (wake_prox_r || wake_touch_r) |=> $stable(ref_lta_r))
		else $error("reference average moved while frozen");
	AST_EXTEND: assert property (cfg_r[2] |-> touch_thr[1:0] == 2'b00
		&& touch_thr[17:2] == 16'((24'(thr_r[15:8]) * 24'(wake_lta_r)) >> 8))
		else $error("extended touch threshold wrong");
	AST_PROX: assert property (sample_valid && !wake_rsd
		&& delta > {8'h00, thr_r[7:0]} |=> wake_prox_r)
		else $error("proximity flag missed");
	AST_RELEASE: assert property (rel_thr <= touch_thr)
		else $error("release threshold above touch threshold");
	AST_TAP_PULSE: assert property (tap_r |=> !tap_r && !swipe_x_r)
		else $error("tap pulse longer than one cycle");
	AST_SWIPE_TIME: assert property (swipe_x_r || swipe_y_r
		|-> $past(el_r) < $past(tmo_r[15:8]))
		else $error("swipe reported after timeout");
	AST_SWIPE_MODE: assert property (cfg_r[4] && gst_r == ptg_pkg::PTG_G_DONE
		&& $stable(cfg_r) |-> !swipe_x_r || $past(gst_r) == ptg_pkg::PTG_G_TOUCH)
		else $error("swipe repeated in one touch");
endmodule

/* File: rtl/ptg_cfg.svh */
// constants: register offsets, field positions, reset values, timing
// Summary of operation
// - reseed level picks up to which channel state the reference reseeds
// - extend option multiplies the touch threshold by four
// - tracking does nothing while the sensing channel has no event
// - reference average is frozen while tracking is on and the sensing channel is active
// - weighted reference delta, 0 to 200 percent, comes off sensing average
// - mode bit: flick reported on release, swipe reported at once
// - coordinate filter 0..3 applies to flick and swipe, not tap
// - swipe needs coordinate change above threshold, per axis
// - tap rejected when movement exceeds half the swipe threshold
// - swipe or flick must finish below the timeout, 16 ms steps
// - tap must release within tap timeout, 16 ms steps
// - advanced offset puts average 8 counts off counts after reseed
// - command channel bits reseed those channels; command resets to zero
// - channel bits plus redo command re-tune channels at bus stop
// - reseed that lands outside the tuning band starts a re-tune
// - wake proximity threshold in counts; proximity halts its average
// - wake touch threshold is register times average over 256
// - four-bit hysteresis code picks fraction from 16-entry table
// - release threshold is touch threshold times one minus fraction
`ifndef PTG_CFG_SVH
`define PTG_CFG_SVH
`define PTG_OFS_REF_GEST    8'h86
`define PTG_OFS_TIMEOUTS    8'h87
`define PTG_OFS_RESEED_CMD  8'h88
`define PTG_OFS_WAKE_THR    8'h89
`define PTG_OFS_WAKE_HYST   8'h8a
`define PTG_RST_REG         16'h0000
`define PTG_RST_CMD         8'h00
// fields of the reference and gesture register, low byte
`define PTG_F_RSD_LVL_LO    0
`define PTG_F_EXTEND        2
`define PTG_F_TRACK_EN      3
`define PTG_F_SWIPE_MODE    4
`define PTG_F_ADV_OFS       5
`define PTG_F_CFILT_LO      6
// fields of the hysteresis register, low byte
`define PTG_F_HYST_LO       0
`define PTG_F_PROJECTED     4
// 8-count reseed offset and 1/8 tuning band shift
`define PTG_RESEED_OFS      16'h0008
`define PTG_BAND_SHIFT      3
// timeout step: 16 ms at 100 MHz
`define PTG_STEP_MS         16
`define PTG_CLK_KHZ         100000
`define PTG_STEP_CYC        (`PTG_STEP_MS * `PTG_CLK_KHZ)
`endif

/* File: rtl/ptg_pkg.sv */
// shared types of the proximity, touch and gesture block
package ptg_pkg;
	// gesture tracker states, gray along idle, touching, reported
	typedef enum logic [1:0] {
		PTG_G_IDLE  = 2'b00,
		PTG_G_TOUCH = 2'b01,
		PTG_G_DONE  = 2'b11
	} ptg_gest_t;
endpackage

/* File: bench/ptg_sensor_model.sv */
// sensor front end model: wake counts, reference counts and trackpad
`timescale 1ns/1ps
module ptg_sensor_model (
	input  wire logic        clk,
	output logic             sample_valid,
	output logic      [15:0] wake_counts,
	output logic      [15:0] ref_counts,
	output logic      [7:0]  ref_weight,
	output logic             tp_touch,
	output logic      [7:0]  tp_x,
	output logic      [7:0]  tp_y
);
	// reference starts at zero; refs moves it for the tracking cases
	initial begin
		sample_valid = 1'b0;
		wake_counts  = 16'h0320;
		ref_counts   = 16'h0000;
		ref_weight   = 8'h00;
		tp_touch     = 1'b0;
		tp_x         = 8'h00;
		tp_y         = 8'h00;
	end

	// one conversion: values change off the falling edge, strobe one cycle
	task automatic take(input logic [15:0] c, input logic t,
			input logic [7:0] x, input logic [7:0] y);
		@(negedge clk);
		wake_counts  = c;
		tp_touch     = t;
		tp_x         = x;
		tp_y         = y;
		sample_valid = 1'b1;
		@(negedge clk);
		sample_valid = 1'b0;
	endtask

	// reference level and tracking weight, changed off the edge
	task automatic refs(input logic [15:0] c, input logic [7:0] w);
		@(negedge clk);
		ref_counts = c;
		ref_weight = w;
	endtask
endmodule

/* File: bench/test_ptg_core.sv */
// self-checking bench of the proximity, touch and gesture core
`timescale 1ns/1ps
module test_ptg_core;
	logic        clk, rst_n, wr_en, redo_tune_cmd, bus_stop, sample_valid;
	logic        tp_touch, wake_prox_r, wake_touch_r;
	logic        swipe_x_r, swipe_y_r, tap_r;
	logic [7:0]  wr_addr, rd_addr, ref_weight, tp_x, tp_y;
	logic [7:0]  reseed_ch_r, retune_ch_r;
	logic [15:0] wr_data, rd_data_r, wake_counts, ref_counts;
	logic [15:0] wake_lta_r, ref_lta_r;
	logic [31:0] seed;
	int          n_fail, samples_checked;

	ptg_core #(.STEP_CYC(16)) i_ptg_core (.clk(clk), .rst_n(rst_n),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_addr(rd_addr), .rd_data_r(rd_data_r),
		.redo_tune_cmd(redo_tune_cmd), .bus_stop(bus_stop),
		.sample_valid(sample_valid), .wake_counts(wake_counts),
		.ref_counts(ref_counts), .ref_weight(ref_weight),
		.tp_touch(tp_touch), .tp_x(tp_x), .tp_y(tp_y),
		.wake_prox_r(wake_prox_r), .wake_touch_r(wake_touch_r),
		.wake_lta_r(wake_lta_r), .ref_lta_r(ref_lta_r),
		.reseed_ch_r(reseed_ch_r), .retune_ch_r(retune_ch_r),
		.swipe_x_r(swipe_x_r), .swipe_y_r(swipe_y_r), .tap_r(tap_r));

	ptg_sensor_model i_ptg_sensor_model (.clk(clk),
		.sample_valid(sample_valid), .wake_counts(wake_counts),
		.ref_counts(ref_counts), .ref_weight(ref_weight),
		.tp_touch(tp_touch), .tp_x(tp_x), .tp_y(tp_y));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// generous: the whole sequence needs a few hundred cycles
	initial begin
		#300_000;
		n_fail++;
		stop_test();
	end

	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// readback masks: reserved command bits and hysteresis byte bits 7:5
	function automatic logic [15:0] rd_exp(input logic [7:0] a,
			input logic [15:0] d);
		if (a == 8'h88) begin
			return d & 16'h00f7;
		end
		return (a == 8'h8a) ? (d & 16'hff1f) : d;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		wr_en   = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge clk);
		wr_en   = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge clk);
		rd_addr = a;
		repeat (2) @(posedge clk);
		#1 chk(rd_data_r, e);
	endtask

	// bus stop, optionally with redo; returns mid-cycle with the reseed and re-tune pulses still visible
	task automatic stop(input logic r);
		@(negedge clk);
		bus_stop      = 1'b1;
		redo_tune_cmd = r;
		@(negedge clk);
		bus_stop      = 1'b0;
		redo_tune_cmd = 1'b0;
	endtask

	// returns mid-cycle, so one-cycle gesture pulses are still visible
	task automatic smp(input logic [15:0] c, input logic t,
			input logic [7:0] x, input logic [7:0] y);
		i_ptg_sensor_model.take(c, t, x, y);
	endtask

	initial begin
		logic [15:0] d;
		rst_n = 1'b0;
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 16'h0000;
		rd_addr = 8'h00;
		redo_tune_cmd = 1'b0;
		bus_stop = 1'b0;
		seed = 32'hf119;
		repeat (6) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 5; i++) rd(8'h86 + 8'(i), 16'h0000);
		rd(8'h85, 16'h0000);
		rd(8'h8b, 16'h0000);
		// random register traffic, read straight back
		repeat (4) begin
			for (int i = 0; i < 5; i++) begin
				seed = xs(seed);
				d = seed[15:0];
				wr(8'h86 + 8'(i), d);
				rd(8'h86 + 8'(i), rd_exp(8'h86 + 8'(i), d));
			end
		end
		stop(1'b0);
		// reseed at stop, offset variants, band check, redo
		wr(8'h86, 16'h0000);
		wr(8'h89, 16'h2014);
		wr(8'h8a, 16'h000f);
		smp(16'h0320, 1'b0, 8'h00, 8'h00);
		wr(8'h88, 16'h0001);
		stop(1'b0);
		chk(16'(reseed_ch_r), 16'h0001);
		chk(16'(retune_ch_r), 16'h0000);
		chk(wake_lta_r, 16'h0320);
		rd(8'h88, 16'h0000);
		wr(8'h86, 16'h0020);
		wr(8'h88, 16'h0001);
		stop(1'b0);
		chk(wake_lta_r, 16'h0328);
		wr(8'h8a, 16'h001f);
		wr(8'h88, 16'h0001);
		stop(1'b0);
		chk(wake_lta_r, 16'h0318);
		wr(8'h8a, 16'h000f);
		wr(8'h86, 16'h0004);
		smp(16'h0100, 1'b0, 8'h00, 8'h00);
		wr(8'h88, 16'h0001);
		stop(1'b0);
		chk(16'(retune_ch_r), 16'h0001);
		wr(8'h88, 16'h0011);
		stop(1'b1);
		chk(16'(retune_ch_r), 16'h0011);
		chk(16'(reseed_ch_r), 16'h0000);
		smp(16'h0320, 1'b0, 8'h00, 8'h00);
		wr(8'h88, 16'h0001);
		stop(1'b0);
		// thresholds: extend hides touch, then touch, hysteresis, release
		// self sensing: counts above the average make the delta
		smp(16'h03e8, 1'b0, 8'h00, 8'h00);
		chk(16'(wake_prox_r), 16'h0001);
		chk(16'(wake_touch_r), 16'h0000);
		chk(wake_lta_r, 16'h032c);
		smp(16'h03e8, 1'b0, 8'h00, 8'h00);
		chk(wake_lta_r, 16'h032c);
		wr(8'h86, 16'h0000);
		smp(16'h03e8, 1'b0, 8'h00, 8'h00);
		chk(16'(wake_touch_r), 16'h0001);
		smp(16'h035e, 1'b0, 8'h00, 8'h00);
		chk(16'(wake_touch_r), 16'h0001);
		smp(16'h0336, 1'b0, 8'h00, 8'h00);
		chk(16'(wake_touch_r), 16'h0000);
		// tracking: idle has no effect, then freeze and weighted subtract
		wr(8'h86, 16'h0008);
		i_ptg_sensor_model.refs(16'h0010, 8'h80);
		smp(16'h03e8, 1'b0, 8'h00, 8'h00);
		chk(wake_lta_r, 16'h0337);
		chk(ref_lta_r, 16'h0010);
		i_ptg_sensor_model.refs(16'h0020, 8'h80);
		smp(16'h03e8, 1'b0, 8'h00, 8'h00);
		chk(wake_lta_r, 16'h0327);
		chk(ref_lta_r, 16'h0010);
		// reference reseeds only up to the selected state
		wr(8'h86, 16'h0009);
		i_ptg_sensor_model.refs(16'h0040, 8'h80);
		smp(16'h03e8, 1'b0, 8'h00, 8'h00);
		chk(wake_lta_r, 16'h02f7);
		wr(8'h86, 16'h000a);
		smp(16'h03e8, 1'b0, 8'h00, 8'h00);
		chk(wake_lta_r, 16'h03e8);
		chk(16'(wake_touch_r), 16'h0000);
		i_ptg_sensor_model.refs(16'h0000, 8'h00);
		// gestures: swipe at once, flick on release, taps, timeouts
		wr(8'h87, 16'hffff);
		wr(8'h86, 16'h0a10);
		smp(16'h0320, 1'b1, 8'h40, 8'h40);
		smp(16'h0320, 1'b1, 8'h54, 8'h40);
		chk(16'({swipe_x_r, swipe_y_r}), 16'h0002);
		smp(16'h0320, 1'b0, 8'h54, 8'h40);
		chk(16'(tap_r), 16'h0000);
		wr(8'h86, 16'h0a00);
		smp(16'h0320, 1'b1, 8'h40, 8'h40);
		smp(16'h0320, 1'b1, 8'h40, 8'h54);
		chk(16'(swipe_y_r), 16'h0000);
		smp(16'h0320, 1'b0, 8'h40, 8'h54);
		chk(16'(swipe_y_r), 16'h0001);
		wr(8'h86, 16'h0ac0);
		smp(16'h0320, 1'b1, 8'h40, 8'h40);
		smp(16'h0320, 1'b0, 8'h45, 8'h40);
		chk(16'(tap_r), 16'h0001);
		smp(16'h0320, 1'b1, 8'h40, 8'h40);
		smp(16'h0320, 1'b0, 8'h54, 8'h40);
		chk(16'(swipe_x_r), 16'h0000);
		smp(16'h0320, 1'b1, 8'h40, 8'h40);
		smp(16'h0320, 1'b0, 8'h46, 8'h40);
		chk(16'(tap_r), 16'h0000);
		wr(8'h87, 16'hff01);
		smp(16'h0320, 1'b1, 8'h40, 8'h40);
		repeat (40) @(posedge clk);
		smp(16'h0320, 1'b0, 8'h40, 8'h40);
		chk(16'(tap_r), 16'h0000);
		wr(8'h87, 16'h01ff);
		wr(8'h86, 16'h0a10);
		smp(16'h0320, 1'b1, 8'h40, 8'h40);
		repeat (40) @(posedge clk);
		smp(16'h0320, 1'b1, 8'h54, 8'h40);
		chk(16'(swipe_x_r), 16'h0000);
		smp(16'h0320, 1'b0, 8'h54, 8'h40);
		stop_test();
	end
endmodule
